// ---- hw/bcsl_bridge.sv ----
/*
 bcsl_bridge: i2c slave front end, command decoder, read pointer and
 status/configuration registers of the host-to-line bridge.
 Assumes an external line engine on ref_clk that takes lineCmd* requests,
 obeys lineAbort and reports results on lineEvt; scl/sda/lineIn are async pins.
*/
// Operation
// - status read ack samples line level
// - reset flag set on reset, config clears
// - single-bit result captured at sample instant
// - second triplet bit captured, else untouched
// - triplet records chosen direction flag
// - decode eight one- or two-byte commands
// - each command repositions the read pointer
// - ack accepted bytes, nack invalid ones
// - pointer code selects status, data, config
// - set pointer anytime; bad code ignored
// - set pointer overrides line command pointer
// - pointer moves on rising ack edge
// - device reset always accepted, aborts line
// - reset and line stop within limits
// - device reset clears settings and all flags but rst and ll
// - config byte needs inverted upper nibble
// - config refused while line busy
// - config updates settings, pointer, reset flag
// - status bit order direction down to busy
// - config bits apu, spu, overdrive
// - busy high while line command runs
`timescale 1ns/1ps
module bcsl_bridge
   import bcsl_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT,
   parameter logic [7:0] CMD_WRITE_BYTE = 8'hA5,
   parameter logic [7:0] CMD_READ_BYTE = 8'h96,
   parameter logic [7:0] CMD_TRIPLET = 8'h78
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   input wire logic lineIn,
   input wire bcsl_evt_type lineEvt,
   output logic lineCmdValid,
   output logic [7:0] lineCmd,
   output logic [7:0] lineParam,
   output logic lineAbort,
   output bcsl_cfg_type lineCfg
);

   typedef struct packed {
      logic sclMeta;
      logic sclSync;
      logic sclPrev;
      logic sdaMeta;
      logic sdaSync;
      logic sdaPrev;
      logic lineMeta;
      logic lineSync;
      bcsl_phase_type phase;
      logic [2:0] bitCnt;
      logic byteFull;
      logic readMode;
      logic [7:0] shift;
      logic [7:0] cmd;
      logic [1:0] byteIdx;
      logic refuse;
      logic sdaOe;
      bcsl_ptr_type ptr;
      logic dirFlag;
      logic tsbFlag;
      logic sbrFlag;
      logic rstFlag;
      logic llFlag;
      logic sdFlag;
      logic ppdFlag;
      logic busyFlag;
      bcsl_cfg_type cfg;
      logic [7:0] readData;
      logic cmdValid;
      logic [7:0] cmdCode;
      logic [7:0] cmdParam;
      logic abort;
   } bcsl_state_type;

   localparam bcsl_state_type STATE_RESET = '{
      phase: PH_IDLE,
      ptr: PTR_STATUS,
      rstFlag: RST_FLAG_RESET,
      shift: BYTE_RESET,
      cmd: BYTE_RESET,
      readData: BYTE_RESET,
      cmdCode: BYTE_RESET,
      cmdParam: BYTE_RESET,
      sclMeta: 1'b1,
      sclSync: 1'b1,
      sclPrev: 1'b1,
      sdaMeta: 1'b1,
      sdaSync: 1'b1,
      sdaPrev: 1'b1,
      default: '0
   };

   bcsl_state_type cur_ff;
   bcsl_state_type nxt_ff;

   function automatic logic isLineCmd(input logic [7:0] code);
      isLineCmd = (code == CMD_LINE_RESET) || (code == CMD_SINGLE_BIT) ||
         (code == CMD_WRITE_BYTE) || (code == CMD_READ_BYTE) || (code == CMD_TRIPLET);
   endfunction : isLineCmd

   function automatic logic needsParam(input logic [7:0] code);
      needsParam = (code == CMD_SET_POINTER) || (code == CMD_WRITE_CONFIG) ||
         (code == CMD_SINGLE_BIT) || (code == CMD_WRITE_BYTE) || (code == CMD_TRIPLET);
   endfunction : needsParam

   function automatic logic [7:0] selectReg(input bcsl_state_type s);
      logic [7:0] st;
      logic [7:0] cf;
      st = '0;
      cf = '0;
      st[ST_DIR] = s.dirFlag;
      st[ST_TSB] = s.tsbFlag;
      st[ST_SBR] = s.sbrFlag;
      st[ST_RST] = s.rstFlag;
      st[ST_LL] = s.llFlag;
      st[ST_SD] = s.sdFlag;
      st[ST_PPD] = s.ppdFlag;
      st[ST_BUSY] = s.busyFlag;
      cf[CFG_APU] = s.cfg.activePullup;
      cf[CFG_SPU] = s.cfg.strongPullup;
      cf[CFG_OWS] = s.cfg.overdrive; // upper nibble reads 0
      case (s.ptr)
         PTR_STATUS: selectReg = st;
         PTR_DATA: selectReg = s.readData;
         PTR_CONFIG: selectReg = cf;
         default: selectReg = st;
      endcase
   endfunction : selectReg

   logic sclRise;
   logic sclFall;
   logic startCond;
   logic stopCond;
   logic ackDecision;
   logic [7:0] regOut;

   always_comb begin
      regOut = selectReg(cur_ff);
      sclRise = cur_ff.sclSync && !cur_ff.sclPrev;
      sclFall = !cur_ff.sclSync && cur_ff.sclPrev;
      startCond = cur_ff.sclSync && cur_ff.sclPrev && cur_ff.sdaPrev && !cur_ff.sdaSync;
      stopCond = cur_ff.sclSync && cur_ff.sclPrev && !cur_ff.sdaPrev && cur_ff.sdaSync;

      // accept or refuse the byte just received
      ackDecision = 1'b0;
      if (cur_ff.byteIdx == 2'd0) begin
         if (cur_ff.shift == CMD_DEVICE_RESET || cur_ff.shift == CMD_SET_POINTER) begin
            ackDecision = 1'b1;
         end else if (cur_ff.shift == CMD_WRITE_CONFIG || isLineCmd(cur_ff.shift)) begin
            ackDecision = !cur_ff.busyFlag;
         end
      end else if (cur_ff.byteIdx == 2'd1 && !cur_ff.refuse && needsParam(cur_ff.cmd)) begin
         if (cur_ff.cmd == CMD_SET_POINTER) begin
            ackDecision = (cur_ff.shift == PTR_CODE_STATUS) ||
               (cur_ff.shift == PTR_CODE_DATA) || (cur_ff.shift == PTR_CODE_CONFIG);
         end else if (cur_ff.cmd == CMD_WRITE_CONFIG) begin
            ackDecision = (cur_ff.shift[7:4] == ~cur_ff.shift[3:0]);
         end else begin
            ackDecision = 1'b1;
         end
      end

      nxt_ff = cur_ff;
      nxt_ff.sclMeta = sclIn;
      nxt_ff.sclSync = cur_ff.sclMeta;
      nxt_ff.sclPrev = cur_ff.sclSync;
      nxt_ff.sdaMeta = sdaIn;
      nxt_ff.sdaSync = cur_ff.sdaMeta;
      nxt_ff.sdaPrev = cur_ff.sdaSync;
      nxt_ff.lineMeta = lineIn;
      nxt_ff.lineSync = cur_ff.lineMeta;
      nxt_ff.cmdValid = 1'b0;
      nxt_ff.abort = 1'b0;

      // line engine results
      if (lineEvt.sbrStrobe) begin
         nxt_ff.sbrFlag = cur_ff.lineSync;
      end
      if (lineEvt.tsbStrobe) begin
         nxt_ff.tsbFlag = cur_ff.lineSync;
      end
      if (lineEvt.dirStrobe) begin
         nxt_ff.dirFlag = lineEvt.dirValue;
      end
      if (lineEvt.presStrobe) begin
         nxt_ff.sdFlag = lineEvt.shortDet;
         nxt_ff.ppdFlag = lineEvt.presence && !lineEvt.shortDet;
      end
      if (lineEvt.dataStrobe) begin
         nxt_ff.readData = lineEvt.data;
      end
      if (lineEvt.spuEnd) begin
         nxt_ff.cfg.strongPullup = 1'b0;
      end
      if (lineEvt.done) begin
         nxt_ff.busyFlag = 1'b0;
      end

      case (cur_ff.phase)
         PH_IDLE: begin
            nxt_ff.sdaOe = 1'b0;
         end
         PH_ADDR, PH_WRITE: begin
            if (sclRise) begin
               nxt_ff.shift = {cur_ff.shift[6:0], cur_ff.sdaSync};
               nxt_ff.bitCnt = cur_ff.bitCnt + 3'd1;
               nxt_ff.byteFull = (cur_ff.bitCnt == 3'd7);
            end else if (sclFall && cur_ff.byteFull) begin
               nxt_ff.byteFull = 1'b0;
               if (cur_ff.phase == PH_ADDR) begin
                  if (cur_ff.shift[7:1] == DEV_ADDR) begin
                     nxt_ff.readMode = cur_ff.shift[0];
                     nxt_ff.sdaOe = 1'b1;
                     nxt_ff.phase = PH_ADDR_ACK;
                  end else begin
                     nxt_ff.phase = PH_IDLE;
                  end
               end else begin
                  nxt_ff.sdaOe = ackDecision;
                  if (cur_ff.byteIdx == 2'd0) begin
                     nxt_ff.cmd = cur_ff.shift;
                     nxt_ff.refuse = !ackDecision;
                  end
                  nxt_ff.phase = PH_WRITE_ACK;
               end
            end
         end
         PH_ADDR_ACK: begin
            if (sclRise && cur_ff.readMode && cur_ff.ptr == PTR_STATUS) begin
               nxt_ff.llFlag = cur_ff.lineSync;
            end
            if (sclFall) begin
               nxt_ff.bitCnt = 3'd0;
               nxt_ff.byteIdx = 2'd0;
               nxt_ff.refuse = 1'b0;
               if (cur_ff.readMode) begin
                  regOut = selectReg(cur_ff);
                  nxt_ff.shift = regOut;
                  nxt_ff.sdaOe = !regOut[7];
                  nxt_ff.phase = PH_READ;
               end else begin
                  nxt_ff.sdaOe = 1'b0;
                  nxt_ff.phase = PH_WRITE;
               end
            end
         end
         PH_WRITE_ACK: begin
            if (sclRise && cur_ff.sdaOe) begin
               if (cur_ff.byteIdx == 2'd0) begin
                  if (cur_ff.cmd == CMD_DEVICE_RESET) begin
                     nxt_ff.abort = 1'b1;
                     nxt_ff.ptr = PTR_STATUS;
                     nxt_ff.rstFlag = 1'b1;
                     nxt_ff.busyFlag = 1'b0;
                     nxt_ff.ppdFlag = 1'b0;
                     nxt_ff.sdFlag = 1'b0;
                     nxt_ff.sbrFlag = 1'b0;
                     nxt_ff.tsbFlag = 1'b0;
                     nxt_ff.dirFlag = 1'b0;
                     nxt_ff.cfg = '0;
                  end else if (isLineCmd(cur_ff.cmd) && !needsParam(cur_ff.cmd)) begin
                     nxt_ff.cmdValid = 1'b1;
                     nxt_ff.cmdCode = cur_ff.cmd;
                     nxt_ff.busyFlag = 1'b1;
                     nxt_ff.ptr = PTR_STATUS;
                  end
               end else if (cur_ff.cmd == CMD_SET_POINTER) begin
                  if (cur_ff.shift == PTR_CODE_DATA) begin
                     nxt_ff.ptr = PTR_DATA;
                  end else if (cur_ff.shift == PTR_CODE_CONFIG) begin
                     nxt_ff.ptr = PTR_CONFIG;
                  end else begin
                     nxt_ff.ptr = PTR_STATUS;
                  end
               end else if (cur_ff.cmd == CMD_WRITE_CONFIG) begin
                  nxt_ff.cfg.activePullup = cur_ff.shift[CFG_APU];
                  nxt_ff.cfg.strongPullup = cur_ff.shift[CFG_SPU];
                  nxt_ff.cfg.overdrive = cur_ff.shift[CFG_OWS];
                  nxt_ff.ptr = PTR_CONFIG;
                  nxt_ff.rstFlag = 1'b0;
               end else begin
                  nxt_ff.cmdValid = 1'b1;
                  nxt_ff.cmdCode = cur_ff.cmd;
                  nxt_ff.cmdParam = cur_ff.shift;
                  nxt_ff.busyFlag = 1'b1;
                  nxt_ff.ptr = PTR_STATUS;
               end
            end
            if (sclFall) begin
               nxt_ff.sdaOe = 1'b0;
               nxt_ff.bitCnt = 3'd0;
               if (cur_ff.byteIdx != 2'd2) begin
                  nxt_ff.byteIdx = cur_ff.byteIdx + 2'd1;
               end
               nxt_ff.phase = PH_WRITE;
            end
         end
         PH_READ: begin
            if (sclRise) begin
               nxt_ff.bitCnt = cur_ff.bitCnt + 3'd1;
               nxt_ff.byteFull = (cur_ff.bitCnt == 3'd7);
            end else if (sclFall) begin
               if (cur_ff.byteFull) begin
                  nxt_ff.byteFull = 1'b0;
                  nxt_ff.sdaOe = 1'b0;
                  nxt_ff.phase = PH_READ_ACK;
               end else begin
                  nxt_ff.shift = {cur_ff.shift[6:0], 1'b0};
                  nxt_ff.sdaOe = !cur_ff.shift[6];
               end
            end
         end
         PH_READ_ACK: begin
            if (sclRise) begin
               nxt_ff.byteFull = !cur_ff.sdaSync;
            end else if (sclFall) begin
               nxt_ff.byteFull = 1'b0;
               if (cur_ff.byteFull) begin
                  regOut = selectReg(cur_ff);
                  nxt_ff.shift = regOut;
                  nxt_ff.sdaOe = !regOut[7];
                  nxt_ff.bitCnt = 3'd0;
                  nxt_ff.phase = PH_READ;
               end else begin
                  nxt_ff.phase = PH_IDLE;
               end
            end
         end
         default: begin
            nxt_ff.phase = PH_IDLE;
         end
      endcase

      // bus conditions end any transfer; an ack being given is released at once
      if (startCond) begin
         nxt_ff.phase = PH_ADDR;
         nxt_ff.bitCnt = 3'd0;
         nxt_ff.byteFull = 1'b0;
         nxt_ff.sdaOe = 1'b0;
      end else if (stopCond) begin
         nxt_ff.phase = PH_IDLE;
         nxt_ff.sdaOe = 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cur_ff <= STATE_RESET;
      end else begin
         cur_ff <= nxt_ff;
      end
   end

   assign sdaOut = 1'b0;
   assign sdaOe = cur_ff.sdaOe;
   assign lineCmdValid = cur_ff.cmdValid;
   assign lineCmd = cur_ff.cmdCode;
   assign lineParam = cur_ff.cmdParam;
   assign lineAbort = cur_ff.abort;
   assign lineCfg = cur_ff.cfg;

endmodule : bcsl_bridge

// ---- hw/bcsl_pkg.sv ----
/*
 bcsl_pkg: shared constants and types of the bridge command/status logic:
 command and pointer codes, status and configuration bit positions,
 reset values, timing limits and the structs that carry line-engine traffic.
 Assumes nothing of its surroundings; imported by the design and the bench.
*/
package bcsl_pkg;

   // function command codes
   localparam logic [7:0] CMD_DEVICE_RESET = 8'hF0;
   localparam logic [7:0] CMD_SET_POINTER = 8'hE1;
   localparam logic [7:0] CMD_WRITE_CONFIG = 8'hD2;
   localparam logic [7:0] CMD_LINE_RESET = 8'hB4;
   localparam logic [7:0] CMD_SINGLE_BIT = 8'h87;

   // pointer codes
   localparam logic [7:0] PTR_CODE_STATUS = 8'hF0;
   localparam logic [7:0] PTR_CODE_DATA = 8'hE1;
   localparam logic [7:0] PTR_CODE_CONFIG = 8'hC3;

   // bridge_status bit positions
   localparam int ST_DIR = 7;
   localparam int ST_TSB = 6;
   localparam int ST_SBR = 5;
   localparam int ST_RST = 4;
   localparam int ST_LL = 3;
   localparam int ST_SD = 2;
   localparam int ST_PPD = 1;
   localparam int ST_BUSY = 0;

   // line_feature_config bit positions
   localparam int CFG_APU = 0;
   localparam int CFG_SPU = 2;
   localparam int CFG_OWS = 3;

   // reset values
   localparam logic RST_FLAG_RESET = 1'b1;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h18;

   // latest finish of a device reset and of line activity after the command ack
   localparam real CLK_PERIOD_NS = 10.0;
   localparam real RESET_DONE_NS = 525.0;
   localparam real LINE_STOP_NS = 262.5;
   localparam int RESET_DONE_CYC = int'($floor(RESET_DONE_NS / CLK_PERIOD_NS));
   localparam int LINE_STOP_CYC = int'($floor(LINE_STOP_NS / CLK_PERIOD_NS));

   typedef enum logic [1:0] {
      PTR_STATUS,
      PTR_DATA,
      PTR_CONFIG
   } bcsl_ptr_type;

   typedef enum logic [2:0] {
      PH_IDLE,
      PH_ADDR,
      PH_ADDR_ACK,
      PH_WRITE,
      PH_WRITE_ACK,
      PH_READ,
      PH_READ_ACK
   } bcsl_phase_type;

   // feature settings handed to the line engine
   typedef struct packed {
      logic overdrive;
      logic strongPullup;
      logic activePullup;
   } bcsl_cfg_type;

   // events reported by the line engine, same clock domain, one-cycle strobes
   typedef struct packed {
      logic done;
      logic sbrStrobe;
      logic tsbStrobe;
      logic dirStrobe;
      logic dirValue;
      logic presStrobe;
      logic presence;
      logic shortDet;
      logic dataStrobe;
      logic [7:0] data;
      logic spuEnd;
   } bcsl_evt_type;

endpackage : bcsl_pkg

// ---- test/bcsl_i2c_host.sv ----
/*
 bcsl_i2c_host: i2c host model for the bridge bench, bit period 125 ns.
 assumes the bench builds an open-drain sda wire with a pull-up.
*/
`timescale 1ns/1ps
module bcsl_i2c_host (
   output logic scl,
   output logic sdaRel,
   input wire logic sdaLine
);
   initial begin
      scl = 1'b1;
      sdaRel = 1'b1;
   end
   // data moves mid-low so the bridge's 3-cycle pin lag never straddles an scl edge
   task automatic bitx(input logic b, output logic r);
      #31 sdaRel = b;
      #31.5 scl = 1'b1;
      #31 r = sdaLine;
      #31.5 scl = 1'b0;
   endtask : bitx
   task automatic start();
      #60 sdaRel = 1'b0;
      #60 scl = 1'b0;
   endtask : start
   task automatic stop();
      #31 sdaRel = 1'b0;
      #31.5 scl = 1'b1;
      #31 sdaRel = 1'b1;
      #60;
   endtask : stop
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bitx(d[i], r);
      end
      bitx(1'b1, r);
      ack = ~r;
   endtask : wbyte
   task automatic rbyte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bitx(1'b1, r);
         d[i] = r;
      end
      bitx(last, r);
   endtask : rbyte
endmodule : bcsl_i2c_host

// ---- test/bcsl_bridge_asserts.sv ----
/*
 bcsl_bridge_asserts: port-level checks of the bridge, bound to every instance.
 assumes scl pin phases of at least six ref_clk cycles.
*/
`timescale 1ns/1ps
module bcsl_bridge_asserts
   import bcsl_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic sclIn,
   input wire logic sdaOut,
   input wire logic sdaOe,
   input wire bcsl_evt_type lineEvt,
   input wire logic lineCmdValid,
   input wire logic lineAbort,
   input wire bcsl_cfg_type lineCfg
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   a_sda_open_drain: assert property (sdaOut == 1'b0)
      else $error("sda data value not low");
   a_oe_scl_low: assert property ($changed(sdaOe) |-> !sclIn)
      else $error("sda moved while scl high");
   a_cmd_on_ack: assert property (lineCmdValid |-> sclIn)
      else $error("line command issued outside ack high phase");
   a_cmd_spacing: assert property (lineCmdValid |=> !lineCmdValid [*8])
      else $error("line command pulse too long or repeated");
   a_abort_on_ack: assert property (lineAbort |-> sclIn && !lineCmdValid)
      else $error("abort outside code ack high phase");
   a_abort_spacing: assert property (lineAbort |=> !lineAbort [*8])
      else $error("abort pulse too long or repeated");
   a_abort_cfg: assert property (lineAbort |-> ##[0:1] lineCfg == 3'b000)
      else $error("settings not cleared by device reset");
   a_cfg_on_ack: assert property ($changed(lineCfg) && !$past(lineEvt.spuEnd) |-> sclIn)
      else $error("settings changed outside ack high phase");
endmodule : bcsl_bridge_asserts

bind bcsl_bridge bcsl_bridge_asserts bcsl_bridge_asserts_inst (
   .ref_clk(ref_clk),
   .rst_n(rst_n),
   .sclIn(sclIn),
   .sdaOut(sdaOut),
   .sdaOe(sdaOe),
   .lineEvt(lineEvt),
   .lineCmdValid(lineCmdValid),
   .lineAbort(lineAbort),
   .lineCfg(lineCfg)
);

// ---- test/bcsl_bridge_tb_top.sv ----
/*
 bcsl_bridge_tb_top: self-checking bench of the bridge; the bench stands in for the line engine.
 assumes the host model's tasks and the default device address.
*/
`timescale 1ns/1ps
module bcsl_bridge_tb_top
   import bcsl_pkg::*;
();
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic lineIn = 1'b0;
   bcsl_evt_type lineEvt = '0;
   bcsl_evt_type ev;
   logic scl, sdaRel, sdaOut, sdaOe, lineCmdValid, lineAbort;
   logic [7:0] lineCmd, lineParam;
   bcsl_cfg_type lineCfg;
   logic [7:0] lastCmd = 8'h00;
   logic [7:0] cmdPulses = 8'h00;
   logic [7:0] abortPulses = 8'h00;
   logic [7:0] lastParam = 8'h00;
   int badCount = 0;
   int checkCount = 0;
   // open drain with pull-up: low if either party pulls
   wire logic sdaLine = sdaRel & ~(sdaOe & ~sdaOut);

   always #5 ref_clk = ~ref_clk;

   bcsl_i2c_host bcsl_i2c_host_inst (.scl(scl), .sdaRel(sdaRel), .sdaLine(sdaLine));
   bcsl_bridge bcsl_bridge_inst (.ref_clk(ref_clk), .rst_n(rst_n), .sclIn(scl), .sdaIn(sdaLine),
      .sdaOut(sdaOut), .sdaOe(sdaOe), .lineIn(lineIn), .lineEvt(lineEvt),
      .lineCmdValid(lineCmdValid), .lineCmd(lineCmd), .lineParam(lineParam),
      .lineAbort(lineAbort), .lineCfg(lineCfg));

   always @(posedge ref_clk) begin
      if (lineCmdValid === 1'b1) begin
         cmdPulses <= cmdPulses + 8'h01;
         lastCmd <= lineCmd;
         lastParam <= lineParam;
      end
      if (lineAbort === 1'b1) begin
         abortPulses <= abortPulses + 8'h01;
      end
   end

   task automatic finish_test();
      $display("checks %0d mismatches %0d", checkCount, badCount);
      if (badCount == 0 && checkCount > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : finish_test

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checkCount++;
      if (got !== exp) begin
         badCount++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // write transfer: address, code, optional parameter; checks all three acks
   task automatic cmd(input logic [7:0] c, input logic hasP, input logic [7:0] p,
                      input logic [1:0] expAck);
      logic aa, a0, a1;
      a1 = 1'b0;
      bcsl_i2c_host_inst.start();
      bcsl_i2c_host_inst.wbyte({DEV_ADDR_DEFAULT, 1'b0}, aa);
      bcsl_i2c_host_inst.wbyte(c, a0);
      if (hasP) begin
         bcsl_i2c_host_inst.wbyte(p, a1);
      end
      bcsl_i2c_host_inst.stop();
      chk("acks", {5'h00, 1'b1, expAck}, {5'h00, aa, a0, a1});
   endtask : cmd

   task automatic rd(input logic [7:0] exp);
      logic aa;
      logic [7:0] d0, d1;
      bcsl_i2c_host_inst.start();
      bcsl_i2c_host_inst.wbyte({DEV_ADDR_DEFAULT, 1'b1}, aa);
      bcsl_i2c_host_inst.rbyte(1'b0, d0);
      bcsl_i2c_host_inst.rbyte(1'b1, d1);
      bcsl_i2c_host_inst.stop();
      chk("read first", exp, d0);
      chk("read repeat", exp, d1);
   endtask : rd

   task automatic setLine(input logic v);
      @(posedge ref_clk);
      lineIn <= v;
   endtask : setLine

   task automatic evt(input bcsl_evt_type e);
      @(posedge ref_clk);
      lineEvt <= e;
      @(posedge ref_clk);
      lineEvt <= '0;
   endtask : evt

   task automatic s_power();
      setLine(1'b1);
      rd(8'h18);
      cmd(CMD_DEVICE_RESET, 1'b0, 8'h00, 2'b10);
      rd(8'h18);
   endtask : s_power

   task automatic s_config();
      cmd(CMD_WRITE_CONFIG, 1'b1, 8'h5A, 2'b11);
      chk("cfg", 8'h04, {5'h00, lineCfg});
      rd(8'h08);
      cmd(CMD_WRITE_CONFIG, 1'b1, 8'h5B, 2'b10);
      rd(8'h08);
      setLine(1'b0);
      cmd(CMD_SET_POINTER, 1'b1, PTR_CODE_STATUS, 2'b11);
      rd(8'h00);
      cmd(CMD_WRITE_CONFIG, 1'b1, 8'hA5, 2'b11);
      chk("cfg", 8'h03, {5'h00, lineCfg});
      rd(8'h05);
      ev = '0;
      ev.spuEnd = 1'b1;
      evt(ev);
      rd(8'h01);
   endtask : s_config

   task automatic s_pointer();
      logic [7:0] codes [3] = '{PTR_CODE_STATUS, PTR_CODE_DATA, PTR_CODE_CONFIG};
      logic [7:0] exps [3] = '{8'h00, 8'h3C, 8'h01};
      ev = '0;
      ev.dataStrobe = 1'b1;
      ev.data = 8'h3C;
      evt(ev);
      for (int i = 0; i < 3; i++) begin
         cmd(CMD_SET_POINTER, 1'b1, codes[i], 2'b11);
         rd(exps[i]);
      end
      cmd(CMD_SET_POINTER, 1'b1, 8'h12, 2'b10);
      rd(8'h01);
   endtask : s_pointer

   task automatic s_line();
      logic [7:0] codes [5] = '{CMD_LINE_RESET, CMD_SINGLE_BIT, 8'hA5, 8'h96, 8'h78};
      logic hasP [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
      cmd(CMD_DEVICE_RESET, 1'b0, 8'h00, 2'b10);
      chk("cfg", 8'h00, {5'h00, lineCfg});
      chk("abort pulses", 8'h02, abortPulses);
      for (int i = 0; i < 5; i++) begin
         cmd(codes[i], hasP[i], 8'h80, {1'b1, hasP[i]});
         chk("line cmd", codes[i], lastCmd);
         if (hasP[i]) begin
            chk("line param", 8'h80, lastParam);
         end
         rd(8'h11);
         if (i == 0) begin
            cmd(CMD_WRITE_CONFIG, 1'b1, 8'h5A, 2'b00);
            cmd(CMD_SET_POINTER, 1'b1, PTR_CODE_CONFIG, 2'b11);
            rd(8'h00);
            cmd(CMD_SET_POINTER, 1'b1, PTR_CODE_STATUS, 2'b11);
         end
         ev = '0;
         ev.done = 1'b1;
         evt(ev);
         rd(8'h10);
      end
      chk("cmd pulses", 8'h05, cmdPulses);
   endtask : s_line

   task automatic s_flags();
      setLine(1'b1);
      cmd(8'h78, 1'b1, 8'h80, 2'b11);
      ev = '0;
      ev.sbrStrobe = 1'b1;
      ev.tsbStrobe = 1'b1;
      ev.dirStrobe = 1'b1;
      ev.dirValue = 1'b1;
      ev.done = 1'b1;
      evt(ev);
      rd(8'hF8);
      setLine(1'b0);
      cmd(CMD_SINGLE_BIT, 1'b1, 8'h00, 2'b11);
      ev = '0;
      ev.sbrStrobe = 1'b1;
      ev.done = 1'b1;
      evt(ev);
      rd(8'hD0);
      cmd(CMD_LINE_RESET, 1'b0, 8'h00, 2'b10);
      ev = '0;
      ev.presStrobe = 1'b1;
      ev.presence = 1'b1;
      ev.done = 1'b1;
      evt(ev);
      rd(8'hD2);
      cmd(8'h96, 1'b0, 8'h00, 2'b10);
      cmd(CMD_DEVICE_RESET, 1'b0, 8'h00, 2'b10);
      rd(8'h10);
      cmd(8'h55, 1'b1, 8'h00, 2'b00);
   endtask : s_flags

   initial begin
      repeat (8) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (6) @(posedge ref_clk);
      s_power();
      s_config();
      s_pointer();
      s_line();
      s_flags();
      finish_test();
   end

   // the sequence needs roughly 175 us; over four times that means a hang
   initial begin
      #800us;
      badCount++;
      finish_test();
   end
endmodule : bcsl_bridge_tb_top
